//--- exc_defs.svh
`ifndef EXC_DEFS_SVH
`define EXC_DEFS_SVH
// Opword line codes
`define LINE_A_CODE 4'ha
`define LINE_F_CODE 4'hf
// Vector numbers
`define VEC_NONPC_BKPT 8'h0c
`define VEC_PC_BKPT 8'h0d
`define VEC_LINE_A 8'h0a
`define VEC_LINE_F 8'h0b
`define VEC_FORMAT_ERR 8'h0e
`define VEC_UNSUPPORTED 8'h3d
`define VEC_TRAP_BASE 8'h20
// Reset values
`define VBR_RESET 32'h0000_0000
`define MASK_RESET 3'h7
`define SP_VEC_ADDR 32'h0000_0000
`define PC_VEC_ADDR 32'h0000_0004
// Frame format window
`define FMT_MIN 4'h4
`define FMT_MAX 4'h7
// Stack pointer step past the first frame longword
`define FRAME_POST_INC 32'h0000_0004
// Configuration fields
`define CCW_MAC 1'h0
`define CCW_DIV 1'h1
`define CCW_ENHANCED_MULTIPLY_ACCUMULATE_PRESENT 1'h1
`define CCW_FPU 1'h0
`define CCW_ISA 4'h2
`define CCW_DEBUG 4'hb
`define MCW_LINE 2'h0
`define MCW_ICWAYS 2'h0
`define MCW_ICSIZE 4'h6
`define MCW_BUSW 2'h0
`define MCW_PUSH 1'h1
`define MCW_DCWAYS 1'h0
`define MCW_DCSIZE 4'h6
`define MCW_RAMSZ 5'h0e
`endif

//--- exc_pkg.sv
package exc_pkg;
	typedef struct packed {
		logic supervisor_flag;
		logic trace_flag;
		logic master_state_flag;
		logic [2:0] interrupt_mask_level;
	} status_s;
	typedef struct packed {
		logic valid;
		logic [31:0] addr;
	} bus_req_s;
	typedef enum logic [2:0] {
		EV_NONE,
		EV_LINE_A,
		EV_LINE_F,
		EV_BKPT,
		EV_FORMAT,
		EV_TRAP,
		EV_UNSUP,
		EV_IRQ
	} exc_kind_e;
endpackage : exc_pkg

//--- exc_unit.sv
`timescale 1ns/1ps
`include "exc_defs.svh"
module exc_unit #(
	parameter logic [7:0] FAMILY_CODE = 8'h5a, // Arbitrary value
	parameter logic [3:0] GENERATION = 4'h3, // Arbitrary value
	parameter logic [3:0] REVISION = 4'h1 // Arbitrary value
) (
	input wire logic SYS_CLK, // Core clock
	input wire logic RST, // Async reset, high
	input wire logic BUS_GRANT, // Bus granted to core
	input wire logic BUS_ACK, // Read data valid
	input wire logic BUS_ERR, // Access or address error on read
	input wire logic [31:0] BUS_RDATA, // Read data
	output exc_pkg::bus_req_s BUS_REQ, // Read request and address
	output logic INTERRUPT_VECTOR_FETCH_CYCLE_REQ, // Interrupt vector fetch cycle
	input wire logic INTERRUPT_VECTOR_FETCH_CYCLE_DONE, // Controller returns vector
	input wire logic [7:0] INTERRUPT_VECTOR_FETCH_CYCLE_VECTOR, // Vector from controller
	input wire logic IRQ_PENDING, // Interrupt recognised
	input wire logic INSN_VALID, // Instruction at final stage
	input wire logic [15:0] OPWORD, // Its opword
	input wire logic LINE_A_DEFINED, // Decoder: line-A op defined
	input wire logic LINE_F_DEFINED, // Decoder: line-F op defined
	input wire logic IS_TRAP, // Trap instruction
	input wire logic [3:0] TRAP_NUM, // Trap number
	input wire logic NEEDS_ABSENT_UNIT, // Valid op, unit missing
	input wire logic IS_RETURN, // Return-from-exception
	input wire logic [31:0] FRAME_WORD0, // Frame first longword
	input wire logic [31:0] FRAME_WORD1, // Frame second longword
	input wire logic INSN_FAULT, // Fault on current instruction
	input wire logic BKPT_HIT, // Breakpoint trigger fired
	input wire logic BKPT_IS_PC, // Last trigger was a PC breakpoint
	input wire logic [31:0] WB_DATA, // Pending register update
	input wire logic [3:0] WB_INDEX, // Pending register index
	output logic [31:0] CORE_CONFIG_WORD, // Data register 0
	output logic [31:0] MEMORY_CONFIG_WORD, // Data register 1
	output logic [31:0] SUPER_SP, // Supervisor stack pointer
	output logic [31:0] PC, // Program counter
	output exc_pkg::status_s STATUS, // Status word
	output logic [31:0] VECTOR_TABLE_BASE, // Vector table base
	output logic LOCAL_MEM_ENABLE, // Cache and RAM enable
	output logic EXC_TAKEN, // Exception entry pulse
	output logic [7:0] EXC_VECTOR, // Vector number taken
	output logic [31:0] EXC_VEC_ADDR, // Vector table address
	output logic [31:0] EXC_STACKED_PC, // PC for the frame
	output logic HALTED, // Fault-on-fault halt
	output logic RUNNING // Executing instructions
);
	import exc_pkg::*;

	// ********************************
	// State
	// ********************************
	typedef enum {
		ST_CONFIG,
		ST_WAIT_GRANT,
		ST_FETCH_SP,
		ST_FETCH_PC,
		ST_FIRST,
		ST_RUN,
		ST_INTERRUPT_VECTOR_FETCH_CYCLE,
		ST_HALT
	} state_e;

	state_e state_reg;
	logic in_exc_reg;
	logic [7:0] vec_next;
	logic exc_now;
	logic [3:0] fmt;
	logic fmt_ok;
	logic [31:0] dreg_reg [0:15];

	assign fmt = FRAME_WORD0[31:28];
	assign fmt_ok = (fmt >= `FMT_MIN) && (fmt <= `FMT_MAX);

	// ********************************
	// Exception detection
	// ********************************
	always_comb
	begin
		vec_next = 8'h00;
		exc_now = 1'b0;
		if (state_reg == ST_RUN && INSN_VALID)
		begin
			if (BKPT_HIT)
			begin
				exc_now = 1'b1;
				vec_next = BKPT_IS_PC ? `VEC_PC_BKPT : `VEC_NONPC_BKPT;
			end
			else if (OPWORD[15:12] == `LINE_A_CODE && !LINE_A_DEFINED)
			begin
				exc_now = 1'b1;
				vec_next = `VEC_LINE_A;
			end
			else if (OPWORD[15:12] == `LINE_F_CODE && !LINE_F_DEFINED)
			begin
				exc_now = 1'b1;
				vec_next = `VEC_LINE_F;
			end
			else if (NEEDS_ABSENT_UNIT)
			begin
				exc_now = 1'b1;
				vec_next = `VEC_UNSUPPORTED;
			end
			else if (IS_RETURN && !fmt_ok)
			begin
				exc_now = 1'b1;
				vec_next = `VEC_FORMAT_ERR;
			end
			else if (IS_TRAP)
			begin
				exc_now = 1'b1;
				vec_next = `VEC_TRAP_BASE + {4'h0, TRAP_NUM};
			end
		end
	end

	// ********************************
	// Sequencer
	// ********************************
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			state_reg <= ST_CONFIG;
		else
		begin
			unique case (state_reg)
				ST_CONFIG: state_reg <= ST_WAIT_GRANT;
				ST_WAIT_GRANT: if (BUS_GRANT) state_reg <= ST_FETCH_SP;
				ST_FETCH_SP:
					if (BUS_ERR) state_reg <= ST_HALT;
					else if (BUS_ACK) state_reg <= ST_FETCH_PC;
				ST_FETCH_PC:
					if (BUS_ERR) state_reg <= ST_HALT;
					else if (BUS_ACK) state_reg <= ST_FIRST;
				ST_FIRST:
					if (INSN_FAULT) state_reg <= ST_HALT;
					else if (INSN_VALID) state_reg <= ST_RUN;
				ST_RUN:
					if (INSN_FAULT && in_exc_reg) state_reg <= ST_HALT;
					else if (!exc_now && IRQ_PENDING) state_reg <= ST_INTERRUPT_VECTOR_FETCH_CYCLE;
				ST_INTERRUPT_VECTOR_FETCH_CYCLE: if (INTERRUPT_VECTOR_FETCH_CYCLE_DONE) state_reg <= ST_RUN;
				ST_HALT: state_reg <= ST_HALT;
			endcase
		end
	end

	// Exception processing window: set by an entry, held until the next instruction in run completes without a fault
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			in_exc_reg <= 1'b0;
		else if (EXC_TAKEN)
			in_exc_reg <= 1'b1;
		else if (state_reg == ST_RUN && INSN_VALID && !INSN_FAULT)
			in_exc_reg <= 1'b0;
	end

	assign BUS_REQ.valid = (state_reg == ST_FETCH_SP) || (state_reg == ST_FETCH_PC);
	assign BUS_REQ.addr = (state_reg == ST_FETCH_PC) ? `PC_VEC_ADDR : `SP_VEC_ADDR;
	assign INTERRUPT_VECTOR_FETCH_CYCLE_REQ = (state_reg == ST_INTERRUPT_VECTOR_FETCH_CYCLE);
	assign HALTED = (state_reg == ST_HALT);
	assign RUNNING = (state_reg == ST_RUN) || (state_reg == ST_FIRST);

	// ********************************
	// Exception outputs
	// ********************************
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			EXC_TAKEN <= 1'b0;
			EXC_VECTOR <= 8'h00;
			EXC_VEC_ADDR <= 32'h0000_0000;
			EXC_STACKED_PC <= 32'h0000_0000;
		end
		else
		begin
			EXC_TAKEN <= 1'b0;
			if (exc_now && !(INSN_FAULT && in_exc_reg))
			begin
				EXC_TAKEN <= 1'b1;
				EXC_VECTOR <= vec_next;
				EXC_VEC_ADDR <= VECTOR_TABLE_BASE + {22'h0, vec_next, 2'b00};
				EXC_STACKED_PC <= PC;
			end
			else if (state_reg == ST_INTERRUPT_VECTOR_FETCH_CYCLE && INTERRUPT_VECTOR_FETCH_CYCLE_DONE)
			begin
				EXC_TAKEN <= 1'b1;
				EXC_VECTOR <= INTERRUPT_VECTOR_FETCH_CYCLE_VECTOR;
				EXC_VEC_ADDR <= VECTOR_TABLE_BASE + {22'h0, INTERRUPT_VECTOR_FETCH_CYCLE_VECTOR, 2'b00};
				EXC_STACKED_PC <= PC;
			end
		end
	end

	// ********************************
	// Status, base, memories
	// ********************************
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			STATUS.supervisor_flag <= 1'b1;
			STATUS.trace_flag <= 1'b0;
			STATUS.master_state_flag <= 1'b0;
			STATUS.interrupt_mask_level <= `MASK_RESET;
			VECTOR_TABLE_BASE <= `VBR_RESET;
			LOCAL_MEM_ENABLE <= 1'b0;
		end
		else if (exc_now && !INSN_FAULT)
		begin
			// Breakpoints leave master flag and mask alone
			STATUS.supervisor_flag <= 1'b1;
			STATUS.trace_flag <= 1'b0;
		end
		else if (state_reg == ST_RUN && INSN_VALID && !INSN_FAULT && IS_RETURN && fmt_ok)
			STATUS <= status_s'({FRAME_WORD0[13], FRAME_WORD0[15], FRAME_WORD0[12],
				FRAME_WORD0[10:8]});
	end

	// ********************************
	// Stack pointer and program counter
	// ********************************
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			SUPER_SP <= 32'h0000_0000;
			PC <= 32'h0000_0000;
		end
		else if (state_reg == ST_FETCH_SP && BUS_ACK && !BUS_ERR)
			SUPER_SP <= BUS_RDATA;
		else if (state_reg == ST_FETCH_PC && BUS_ACK && !BUS_ERR)
			PC <= BUS_RDATA;
		else if (state_reg == ST_RUN && INSN_VALID && !INSN_FAULT && !exc_now
			&& IS_RETURN && fmt_ok)
		begin
			SUPER_SP <= SUPER_SP + `FRAME_POST_INC + {28'h0, fmt};
			PC <= FRAME_WORD1;
		end
	end

	// ********************************
	// Data registers and configuration
	// ********************************
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			for (int i = 0; i < 16; i++)
				dreg_reg[i] <= 32'h0000_0000;
		end
		else if (state_reg == ST_CONFIG)
		begin
			dreg_reg[0] <= {FAMILY_CODE, GENERATION, REVISION, `CCW_MAC, `CCW_DIV,
				`CCW_ENHANCED_MULTIPLY_ACCUMULATE_PRESENT, `CCW_FPU, 4'h0, `CCW_ISA, `CCW_DEBUG};
			dreg_reg[1] <= {`MCW_LINE, `MCW_ICWAYS, `MCW_ICSIZE, 8'h00, `MCW_BUSW,
				`MCW_PUSH, `MCW_DCWAYS, `MCW_DCSIZE, `MCW_RAMSZ, 3'h0};
		end
		else if (RUNNING && INSN_VALID && !INSN_FAULT && !exc_now && !IS_RETURN)
			dreg_reg[WB_INDEX] <= WB_DATA;
	end

	assign CORE_CONFIG_WORD = dreg_reg[0];
	assign MEMORY_CONFIG_WORD = dreg_reg[1];

	// ********************************
	// Checks
	// ********************************
	sequence s_sp_done;
		state_reg == ST_FETCH_SP && BUS_ACK && !BUS_ERR;
	endsequence

	property p_reset_cfg;
		@(posedge SYS_CLK) $fell(RST) |-> ##1 (CORE_CONFIG_WORD[7:0] == 8'h2b
			&& MEMORY_CONFIG_WORD[7:3] == 5'h0e);
	endproperty
	a_reset_cfg: assert property (p_reset_cfg) else $error("config words not loaded");

	property p_status_reset;
		@(posedge SYS_CLK) disable iff (RST) $past(RST) |-> STATUS.supervisor_flag
			&& STATUS.interrupt_mask_level == 3'h7 && VECTOR_TABLE_BASE == 32'h0;
	endproperty
	a_status_reset: assert property (p_status_reset) else $error("reset status wrong");

	property p_pc_fetch;
		@(posedge SYS_CLK) disable iff (RST) s_sp_done |=> BUS_REQ.valid
			&& BUS_REQ.addr == 32'h4;
	endproperty
	a_pc_fetch: assert property (p_pc_fetch) else $error("PC fetch not at 4");

	property p_early_err;
		@(posedge SYS_CLK) disable iff (RST) (BUS_REQ.valid && BUS_ERR) |=> HALTED [*2];
	endproperty
	a_early_err: assert property (p_early_err) else $error("boot error did not halt");

	property p_halt_stays;
		@(posedge SYS_CLK) disable iff (RST) HALTED |=> HALTED;
	endproperty
	a_halt_stays: assert property (p_halt_stays) else $error("left halt");

	property p_line_a;
		@(posedge SYS_CLK) disable iff (RST) (state_reg == ST_RUN && INSN_VALID && !BKPT_HIT
			&& OPWORD[15:12] == 4'ha && !LINE_A_DEFINED && !INSN_FAULT)
			|=> EXC_TAKEN && EXC_VECTOR == 8'h0a;
	endproperty
	a_line_a: assert property (p_line_a) else $error("line-A not raised");

	property p_bkpt;
		@(posedge SYS_CLK) disable iff (RST) (state_reg == ST_RUN && INSN_VALID && BKPT_HIT
			&& !INSN_FAULT) |=> EXC_TAKEN && !INTERRUPT_VECTOR_FETCH_CYCLE_REQ
			&& EXC_VECTOR == ($past(BKPT_IS_PC) ? 8'h0d : 8'h0c) && $stable(STATUS.interrupt_mask_level);
	endproperty
	a_bkpt: assert property (p_bkpt) else $error("breakpoint vector wrong");

	property p_vec_addr;
		@(posedge SYS_CLK) disable iff (RST) EXC_TAKEN |->
			EXC_VEC_ADDR == $past(VECTOR_TABLE_BASE) + {22'h0, EXC_VECTOR, 2'b00};
	endproperty
	a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");

	property p_interrupt_vector_fetch_cycle;
		@(posedge SYS_CLK) disable iff (RST) (INTERRUPT_VECTOR_FETCH_CYCLE_REQ && INTERRUPT_VECTOR_FETCH_CYCLE_DONE) |=> EXC_TAKEN
			&& EXC_VECTOR == $past(INTERRUPT_VECTOR_FETCH_CYCLE_VECTOR);
	endproperty
	a_interrupt_vector_fetch_cycle: assert property (p_interrupt_vector_fetch_cycle) else $error("interrupt vector not used");

endmodule : exc_unit

//--- exc_partner.sv
`timescale 1ns/1ps
// ****
// Boot memory and interrupt controller
// ****
module exc_partner (
	input wire logic clk, // Core clock
	input wire logic rst, // Async reset, high
	input exc_pkg::bus_req_s req, // Boot read request
	input wire logic interrupt_vector_fetch_cycle_req, // Vector fetch cycle
	input wire logic [31:0] sp_val, // Word at 0
	input wire logic [31:0] pc_val, // Word at 4
	input wire logic [7:0] vec_val, // Vector to hand back
	input wire logic [1:0] delay, // Wait states
	input wire logic err_mode, // Answer with an error
	output logic ack, // Read done
	output logic err, // Read failed
	output logic [31:0] rdata, // Read data
	output logic interrupt_vector_fetch_cycle_done, // Vector valid
	output logic [7:0] vector // Returned vector
);
	import exc_pkg::*;
	logic [1:0] wait_reg;
	// Stale read data stays inverted so a late sample never looks valid; the stale vector flips every cycle
	always_ff @(negedge clk or posedge rst)
	begin
		if (rst)
		begin
			ack <= 1'b0;
			err <= 1'b0;
			rdata <= 32'h0;
			wait_reg <= 2'h0;
		end
		else if (ack || err)
		begin
			ack <= 1'b0;
			err <= 1'b0;
			rdata <= ~rdata;
			wait_reg <= 2'h0;
		end
		else if (req.valid && wait_reg == delay)
		begin
			ack <= !err_mode;
			err <= err_mode;
			rdata <= (req.addr == 32'h4) ? pc_val : sp_val;
		end
		else if (req.valid)
			wait_reg <= wait_reg + 2'h1;
	end
	always_ff @(negedge clk or posedge rst)
	begin
		if (rst)
		begin
			interrupt_vector_fetch_cycle_done <= 1'b0;
			vector <= 8'h0;
		end
		else if (interrupt_vector_fetch_cycle_req && !interrupt_vector_fetch_cycle_done)
		begin
			interrupt_vector_fetch_cycle_done <= 1'b1;
			vector <= vec_val;
		end
		else
		begin
			interrupt_vector_fetch_cycle_done <= 1'b0;
			vector <= ~vector;
		end
	end
endmodule : exc_partner

//--- cpu_exception_and_reset_unit_bench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
	begin \
		samples_checked++; \
		if ((got) !== (ex)) \
		begin \
			fails++; \
			$display("mismatch %s exp %h got %h", nm, ex, got); \
		end \
	end
module cpu_exception_and_reset_unit_bench;
	import exc_pkg::*;
	localparam logic [7:0] FAM = 8'h5a; // Arbitrary value
	localparam logic [3:0] GEN = 4'h3; // Arbitrary value
	localparam logic [3:0] REV = 4'h1; // Arbitrary value
	localparam logic [31:0] CCW_EXP = {FAM, GEN, REV, 16'h602b};
	localparam logic [31:0] MCW_EXP = 32'h0600_2670;
	logic clk = 0, rst = 1, grant = 0, irq = 0, iv = 0, la = 0, lf = 0, trp = 0, uns = 0;
	logic ret = 0, flt = 0, bk = 0, bkpc = 0, emode = 0;
	logic [15:0] op = 16'h0;
	logic [3:0] tn = 4'h0, wbi = 4'h5;
	logic [31:0] w0 = 32'h0, w1 = 32'h0, wbd = 32'h0, sp = 32'h0, pcv = 32'h0, sp_exp;
	logic [7:0] vec = 8'h0;
	logic [1:0] dly = 2'h0;
	bus_req_s req;
	status_s st;
	logic ack, berr, iackr, iackd, lme, ext, halted, running;
	logic [31:0] rd, ccw, mcw, ssp, pc, vector_table_base, exa, expc;
	logic [7:0] iv8, exv;
	logic [39:0] note;
	logic [3:0] mi;
	logic [39:0] expq[$];
	int fails = 0, samples_checked = 0, cyc = 0, i;
	exc_unit #(.FAMILY_CODE(FAM), .GENERATION(GEN), .REVISION(REV)) exc_unit_inst (
		.SYS_CLK(clk), .RST(rst), .BUS_GRANT(grant), .BUS_ACK(ack), .BUS_ERR(berr),
		.BUS_RDATA(rd), .BUS_REQ(req), .INTERRUPT_VECTOR_FETCH_CYCLE_REQ(iackr), .INTERRUPT_VECTOR_FETCH_CYCLE_DONE(iackd),
		.INTERRUPT_VECTOR_FETCH_CYCLE_VECTOR(iv8), .IRQ_PENDING(irq), .INSN_VALID(iv), .OPWORD(op),
		.LINE_A_DEFINED(la), .LINE_F_DEFINED(lf), .IS_TRAP(trp), .TRAP_NUM(tn),
		.NEEDS_ABSENT_UNIT(uns), .IS_RETURN(ret), .FRAME_WORD0(w0), .FRAME_WORD1(w1),
		.INSN_FAULT(flt), .BKPT_HIT(bk), .BKPT_IS_PC(bkpc), .WB_DATA(wbd), .WB_INDEX(wbi),
		.CORE_CONFIG_WORD(ccw), .MEMORY_CONFIG_WORD(mcw), .SUPER_SP(ssp), .PC(pc),
		.STATUS(st), .VECTOR_TABLE_BASE(vector_table_base), .LOCAL_MEM_ENABLE(lme), .EXC_TAKEN(ext),
		.EXC_VECTOR(exv), .EXC_VEC_ADDR(exa), .EXC_STACKED_PC(expc), .HALTED(halted),
		.RUNNING(running));
	exc_partner exc_partner_inst (.clk(clk), .rst(rst), .req(req), .interrupt_vector_fetch_cycle_req(iackr),
		.sp_val(sp), .pc_val(pcv), .vec_val(vec), .delay(dly), .err_mode(emode),
		.ack(ack), .err(berr), .rdata(rd), .interrupt_vector_fetch_cycle_done(iackd), .vector(iv8));
	// ****
	// Clock, watchdog and result monitor
	// ****
	always #25 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			complete_run;
		end
	end
	always @(negedge clk)
	begin
		if (ext === 1'b1)
		begin
			if (expq.size() == 0)
			begin
				fails++;
				$display("mismatch exc_taken exp 0 got 1");
			end
			else
			begin
				note = expq.pop_front();
				`CHK("exc_vector", note[39:32], exv)
				`CHK("exc_vec_addr", note[31:0], exa)
			end
		end
	end
	// ****
	// Driver tasks
	// ****
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	task automatic fire(input logic [7:0] v, input bit exc);
		if (exc)
			expq.push_back({v, 22'h0, v, 2'h0});
		iv = 1'b1;
		@(negedge clk);
		iv = 1'b0;
		{la, lf, trp, uns, ret, flt, bk, bkpc} = 8'h0;
		wbi = 4'h5;
		repeat (3) @(negedge clk);
	endtask : fire
	task automatic do_reset;
		rst = 1'b1;
		grant = 1'b0;
		repeat (6) @(negedge clk);
		`CHK("status_rst", 6'h27, st)
		`CHK("halted_rst", 1'b0, halted)
		rst = 1'b0;
		@(negedge clk);
		`CHK("core_cfg", CCW_EXP, ccw)
		`CHK("mem_cfg", MCW_EXP, mcw)
		`CHK("vbr", 32'h0, vector_table_base)
		`CHK("mem_enable", 1'b0, lme)
	endtask : do_reset
	task automatic boot(input bit e);
		bit seen;
		seen = 0;
		sp = $urandom & 32'hffff_fffc;
		pcv = $urandom & 32'hffff_fffe;
		dly = 2'($urandom);
		emode = e;
		grant = 1'b1;
		for (int k = 0; k < 60; k++)
		begin
			@(negedge clk);
			if (req.valid === 1'b1)
				seen = 1;
			else if (seen)
				break;
		end
		if (e)
		begin
			`CHK("halted_boot", 1'b1, halted)
		end
		else
		begin
			`CHK("super_sp", sp, ssp)
			`CHK("pc", pcv, pc)
			wbi = 4'h0;
			wbd = $urandom;
			fire(8'h0, 0);
			`CHK("writeback", wbd, ccw)
			`CHK("running", 1'b1, running)
		end
	endtask : boot
	// ****
	// Main sequence
	// ****
	initial
	begin
		void'($urandom(32'h5fb4));
		do_reset;
		boot(0);
		// Pending update on an excepting instruction must be dropped
		wbi = 4'h1;
		wbd = $urandom;
		op = 16'ha000;
		fire(8'h0a, 1);
		`CHK("mem_cfg_kept", MCW_EXP, mcw)
		la = 1'b1;
		fire(8'h0, 0);
		op = 16'hf000;
		fire(8'h0b, 1);
		lf = 1'b1;
		fire(8'h0, 0);
		// A line-F opword left over would outrank the return
		op = 16'h0000;
		sp_exp = sp;
		for (int f = 4; f < 8; f++)
		begin
			w0 = {4'(f), 12'h0, (f == 7) ? 16'h0300 : 16'h2300};
			w1 = $urandom & 32'hffff_fffe;
			sp_exp = sp_exp + 32'(4 + f);
			ret = 1'b1;
			fire(8'h0, 0);
			`CHK("ret_sp", sp_exp, ssp)
			`CHK("ret_pc", w1, pc)
			`CHK("ret_status", {f != 7, 5'h3}, st)
		end
		tn = 4'($urandom);
		trp = 1'b1;
		fire(8'h20 + {4'h0, tn}, 1);
		`CHK("trap_super", 1'b1, st.supervisor_flag)
		w0 = 32'h3000_0000;
		ret = 1'b1;
		fire(8'h0e, 1);
		w0 = 32'h8000_0000;
		ret = 1'b1;
		fire(8'h0e, 1);
		`CHK("stacked_pc", w1, expc)
		mi = {st.master_state_flag, st.interrupt_mask_level};
		bk = 1'b1;
		fire(8'h0c, 1);
		bk = 1'b1;
		bkpc = 1'b1;
		fire(8'h0d, 1);
		`CHK("bkpt_m_i", mi, {st.master_state_flag, st.interrupt_mask_level})
		uns = 1'b1;
		fire(8'h3d, 1);
		vec = 8'h40 | 8'($urandom);
		expq.push_back({vec, 22'h0, vec, 2'h0});
		irq = 1'b1;
		for (i = 0; i < 20 && iackr !== 1'b1; i++)
			@(negedge clk);
		irq = 1'b0;
		`CHK("interrupt_vector_fetch_cycle_req", 1'b1, iackr)
		repeat (4) @(negedge clk);
		// Fault while the previous exception is still being handled
		op = 16'ha000;
		fire(8'h0a, 1);
		flt = 1'b1;
		fire(8'h0, 0);
		`CHK("halted", 1'b1, halted)
		fire(8'h0, 0);
		`CHK("halted_held", 1'b1, halted)
		do_reset;
		boot(1);
		`CHK("pending_exc", 0, expq.size())
		complete_run;
	end
endmodule : cpu_exception_and_reset_unit_bench
